// file: include/pfcc_pkg.sv
// Purpose: shared constants and carriers for the priority flow control block
// Assumes: 50 MHz system clock, 10 Gb/s link pause quantum of 51.2 ns
// Notes:   register map offsets are byte addresses on a 32-bit bus
package pfcc_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   // one pause quantum, 512 bit times at 10 Gb/s = 51.2 ns, in ps
   localparam logic [16:0] QUANTUM_PS = 17'h0C800;
   localparam logic [16:0] CLK_PERIOD_PS = 17'(1000000 / CLK_MHZ);

   // ----------------------------------------------------------------
   // frame fields
   // ----------------------------------------------------------------
   localparam int NPRIO = 8;
   localparam logic [15:0] QUANTA_RST = 16'hFFFF;
   localparam logic [15:0] REFRESH_RST = 16'hFF00;
   localparam logic [15:0] XON_QUANTA = 16'h0000;
   localparam logic [15:0] P0_ENABLE = 16'h0001;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_QUANTA = 8'h04;
   localparam logic [7:0] ADDR_REFRESH = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_INT_STS = 8'h10;
   localparam logic [7:0] ADDR_INT_MASK = 8'h14;
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_RX_EN = 1;
   localparam int CTRL_AUTO_XON = 2;
   localparam logic [2:0] CTRL_RST = 3'h7;
   localparam int STS_REQ = 0;
   localparam int STS_PAUSED_LSB = 8;
   localparam int INT_XOFF = 0;
   localparam int INT_XON = 1;
   localparam int INT_PSTART = 2;
   localparam int INT_PEND = 3;
   localparam int INT_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] prio_en;
      logic [NPRIO-1:0][15:0] quanta;
   } pfcc_frame_type;

   typedef struct packed {
      logic err_free;
      logic is_ctrl;
      logic pfc_match;
      logic [15:0] prio_en;
      logic [NPRIO-1:0][15:0] quanta;
   } pfcc_rx_info_type;
endpackage

// file: hw/pfcc_tx_gen.sv
// Purpose: builds priority 0 pause frames from the client request
// Assumes: tick is a one-cycle pulse per elapsed pause quantum
// Notes:   a frame request is a one-cycle pulse to the transmit engine
`timescale 1ns/1ps
module pfcc_tx_gen import pfcc_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic tick,
   // configuration
   input wire logic tx_en,
   input wire logic auto_xon,
   input wire logic [15:0] quanta,
   input wire logic [15:0] refresh,
   // client request
   input wire logic req,
   // frame request and events
   output logic frame_valid_r,
   output pfcc_frame_type frame_r,
   output logic xoff_evt_r,
   output logic xon_evt_r
);
   logic req_d_r;
   logic [15:0] elapsed_r;
   logic refresh_due;
   logic send_xoff;
   logic send_xon;
   pfcc_frame_type frame_nxt;

   // refresh fires before the far end's pause runs out
   assign refresh_due = req & req_d_r & (refresh != 16'h0000) &
                        (elapsed_r >= refresh);                  // [R05]
   assign send_xoff = tx_en & ((req & ~req_d_r) | refresh_due); // [R04]
   // release sends nothing unless automatic xon is on
   assign send_xon = tx_en & auto_xon & ~req & req_d_r;  // [R07] [R10]

   // request history for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_d_r <= 1'b0;
      end else if (ce) begin
         req_d_r <= req;
      end
   end

   // quanta since the last frame; saturates so it never wraps to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         elapsed_r <= 16'h0000;
      end else if (ce) begin
         if (send_xoff | send_xon) begin
            elapsed_r <= 16'h0000;
         end else if (tick & req & (elapsed_r != 16'hFFFF)) begin
            elapsed_r <= elapsed_r + 16'h0001;
         end
      end
   end

   // only priority 0 is enabled; unused quanta and bits stay zero
   always_comb begin
      frame_nxt = '0;
      frame_nxt.prio_en = P0_ENABLE;                             // [R11]
      frame_nxt.quanta[0] = send_xon ? XON_QUANTA : quanta;      // [R07]
   end

   // frame request and event pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_valid_r <= 1'b0;
         frame_r <= '0;
         xoff_evt_r <= 1'b0;
         xon_evt_r <= 1'b0;
      end else if (ce) begin
         frame_valid_r <= send_xoff | send_xon;
         frame_r <= frame_nxt;
         xoff_evt_r <= send_xoff;
         xon_evt_r <= send_xon;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking tx_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   xoff_on_rise_a: assert property ( // [R04]
      ce && tx_en && req && !req_d_r |=>
      frame_valid_r && frame_r.quanta[0] == $past(quanta))
      else $error("no xoff frame after request rose");
   refresh_bound_a: assert property ( // [R05]
      ce && tx_en && req && req_d_r && refresh != 16'h0000 &&
      elapsed_r == refresh |=> frame_valid_r && elapsed_r == 16'h0000)
      else $error("refresh frame missing at refresh count");
   xon_zero_a: assert property ( // [R07]
      ce && tx_en && auto_xon && !req && req_d_r |=>
      frame_valid_r && frame_r.quanta[0] == XON_QUANTA)
      else $error("xon frame missing or quanta not zero");
   no_xon_frame_a: assert property ( // [R10]
      ce && !auto_xon && !req && req_d_r |=> !frame_valid_r)
      else $error("frame sent on release without auto xon");
   enable_field_a: assert property ( // [R11]
      frame_valid_r |-> frame_r.prio_en == P0_ENABLE &&
      frame_r.quanta[7:1] == '0)
      else $error("enable vector or spare quanta malformed");
   xoff_xon_c: cover property (xoff_evt_r ##[1:1000] xon_evt_r);
endmodule // pfcc_tx_gen

// file: hw/pfcc_rx_pause.sv
// Purpose: per-priority pause counters driven by received pause frames
// Assumes: frame_end marks the last cycle of a parsed received frame
// Notes:   counting starts only once the paused flag is up
`timescale 1ns/1ps
module pfcc_rx_pause import pfcc_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic tick,
   // configuration
   input wire logic rx_en,
   // parsed frame
   input wire logic frame_end,
   input pfcc_rx_info_type info,
   // paused flags, one per priority
   output wire logic [NPRIO-1:0] paused
);
   logic good_pfc;

   // only an error-free pause control frame acts on the counters
   assign good_pfc = frame_end & info.err_free & info.is_ctrl &
                     info.pfc_match & rx_en;

   for (genvar i = 0; i < NPRIO; i++) begin : g_prio
      logic [15:0] cnt_r;
      logic [15:0] cnt_nxt;
      logic paused_r;

      // a new frame reloads; a zero load ends the pause at once
      always_comb begin
         cnt_nxt = cnt_r;
         if (good_pfc & info.prio_en[i]) begin
            cnt_nxt = info.quanta[i];                    // [R08] [R09]
         end else if (tick & paused_r) begin
            cnt_nxt = cnt_r - 16'h0001;                          // [R12]
         end
      end

      // flag follows the counter in the same cycle it is loaded
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt_r <= 16'h0000;
            paused_r <= 1'b0;
         end else if (ce) begin
            cnt_r <= cnt_nxt;
            paused_r <= (cnt_nxt != 16'h0000);                   // [R12]
         end
      end
      assign paused[i] = paused_r;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking rx_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   pause_load_a: assert property ( // [R08]
      ce && good_pfc && info.prio_en[0] && info.quanta[0] != 16'h0000
      |=> paused[0] && g_prio[0].cnt_r == $past(info.quanta[0]))
      else $error("nonzero pause did not pause priority 0");
   xon_clear_a: assert property ( // [R09]
      ce && good_pfc && info.prio_en[0] && info.quanta[0] == 16'h0000
      |=> !paused[0])
      else $error("zero quanta did not end pause at once");
   count_down_a: assert property ( // [R12]
      ce && tick && paused[0] && !(good_pfc && info.prio_en[0]) |=>
      g_prio[0].cnt_r == $past(g_prio[0].cnt_r) - 16'h0001 &&
      paused[0] == (g_prio[0].cnt_r != 16'h0000))
      else $error("pause counter or flag out of step");
   pause_c: cover property (!paused[0] ##1 paused[0] ##[1:1000] !paused[0]);
endmodule // pfcc_rx_pause

// file: hw/pfcc_top.sv
// Purpose: priority 0 flow control inside the MAC, with register access
// Assumes: AXI4-Lite slave on aclk; frame parsing and transmit outside
// Notes:   one write and one read may be outstanding at a time
`timescale 1ns/1ps

// Functional notes
// R01: flow control off: good control frames forwarded
// R02: client drops forwarded control frames itself
// R03: client requests pause above seven eighths full
// R04: request sends pause frame, configured quanta
// R05: held request resends frame at refresh count
// R06: client releases request below three quarters
// R07: auto xon release sends zero quanta frame
// R08: nonzero received pause raises paused flag
// R09: zero quanta frame drops paused flag immediately
// R10: no auto xon: release sends nothing
// R11: enable field has one bit per priority
// R12: per-priority down-counter holds paused while nonzero
// R13: client request uses hysteresis between thresholds
module pfcc_top import pfcc_pkg::*; (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output wire logic s_axi_wready,
   output wire logic [1:0] s_axi_bresp,
   output wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output wire logic s_axi_arready,
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0] s_axi_rresp,
   output wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // client pause request
   input wire logic tx_prio0_pause_request,
   // to transmit engine
   output wire logic tx_pfc_frame_valid,
   output pfcc_frame_type tx_pfc_frame,
   // from receive parser
   input wire logic rx_frame_end,
   input pfcc_rx_info_type rx_frame_info,
   // to client
   output wire logic rx_prio0_paused,
   output wire logic rx_client_frame_done,
   output wire logic rx_client_frame_good,
   // interrupt
   output wire logic irq
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [16:0] acc_r;
   logic [16:0] acc_sum;
   logic tick_r;
   logic [2:0] ctrl_r;
   logic [15:0] quanta_r;
   logic [15:0] refresh_r;
   logic [INT_W-1:0] int_sts_r;
   logic [INT_W-1:0] int_sts_nxt;
   logic [INT_W-1:0] int_mask_r;
   logic [INT_W-1:0] int_evt;
   logic [INT_W-1:0] int_clr;
   logic irq_r;
   logic awready_r;
   logic wready_r;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic do_write;
   logic [31:0] wmask;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;
   logic done_r;
   logic good_r;
   logic paused0_d_r;
   logic [NPRIO-1:0] paused;
   logic xoff_evt;
   logic xon_evt;

   // bit mask of the byte lanes that the write strobes enable
   assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}},
                   {8{wstrb_r[0]}}};

   // ----------------------------------------------------------------
   // pause quantum tick
   // ----------------------------------------------------------------
   // fractional accumulator: 51.2 ns is not a whole number of cycles,
   // so ticks fall 2 or 3 cycles apart, 2.56 on average, with no long-term drift
   assign acc_sum = acc_r + CLK_PERIOD_PS;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_r <= 17'h00000;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= (acc_sum >= QUANTUM_PS);
         acc_r <= (acc_sum >= QUANTUM_PS) ? acc_sum - QUANTUM_PS : acc_sum;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   // address and data are taken in either order; each ready drops
   // after its handshake and rises again when the response is taken
   assign do_write = aw_held_r & w_held_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         waddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid & awready_r) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & wready_r) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r & s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // write decode; status is read-only, so writing it is an error
   always_comb begin
      case (waddr_r)
         ADDR_CTRL, ADDR_QUANTA, ADDR_REFRESH,
         ADDR_INT_STS, ADDR_INT_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
         quanta_r <= QUANTA_RST;
         refresh_r <= REFRESH_RST;
         int_mask_r <= '0;
      end else if (ce & do_write) begin
         case (waddr_r)
            ADDR_CTRL: ctrl_r <= (ctrl_r & ~wmask[2:0]) |
                                 (wdata_r[2:0] & wmask[2:0]);
            ADDR_QUANTA: quanta_r <= (quanta_r & ~wmask[15:0]) |
                                     (wdata_r[15:0] & wmask[15:0]);
            ADDR_REFRESH: refresh_r <= (refresh_r & ~wmask[15:0]) |
                                       (wdata_r[15:0] & wmask[15:0]);
            ADDR_INT_MASK: int_mask_r <= (int_mask_r & ~wmask[3:0]) |
                                         (wdata_r[3:0] & wmask[3:0]);
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   always_comb begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         ADDR_CTRL: rd_word[2:0] = ctrl_r;
         ADDR_QUANTA: rd_word[15:0] = quanta_r;
         ADDR_REFRESH: rd_word[15:0] = refresh_r;
         ADDR_STATUS: begin
            rd_word[STS_REQ] = tx_prio0_pause_request;
            rd_word[STS_PAUSED_LSB +: NPRIO] = paused;
         end
         ADDR_INT_STS: rd_word[INT_W-1:0] = int_sts_r;
         ADDR_INT_MASK: rd_word[INT_W-1:0] = int_mask_r;
         default: rd_hit = 1'b0;
      endcase
   end

   // one read outstanding; data captured at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid & arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // a new event in the clearing cycle survives: set wins over clear
   assign int_evt = {paused0_d_r & ~paused[0], paused[0] & ~paused0_d_r,
                     xon_evt, xoff_evt};
   assign int_clr = (do_write & (waddr_r == ADDR_INT_STS)) ?
                    (wdata_r[INT_W-1:0] & {INT_W{wstrb_r[0]}}) : '0;
   assign int_sts_nxt = (int_sts_r & ~int_clr) | int_evt;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_sts_r <= '0;
         paused0_d_r <= 1'b0;
         irq_r <= 1'b0;
      end else if (ce) begin
         int_sts_r <= int_sts_nxt;
         paused0_d_r <= paused[0];
         irq_r <= |(int_sts_nxt & int_mask_r);
      end
   end

   // ----------------------------------------------------------------
   // receive frames toward the client
   // ----------------------------------------------------------------
   // with reception off every good control frame goes up marked good;
   // a frame the pause logic acted on is marked for dropping
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r <= 1'b0;
         good_r <= 1'b0;
      end else if (ce) begin
         done_r <= rx_frame_end;
         good_r <= rx_frame_end & rx_frame_info.err_free &
                   ~(ctrl_r[CTRL_RX_EN] & rx_frame_info.is_ctrl &
                     rx_frame_info.pfc_match);                   // [R01]
      end
   end

   // ----------------------------------------------------------------
   // transmit and receive engines
   // ----------------------------------------------------------------
   pfcc_tx_gen u_tx (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(tick_r),
      .tx_en(ctrl_r[CTRL_TX_EN]),
      .auto_xon(ctrl_r[CTRL_AUTO_XON]),
      .quanta(quanta_r),
      .refresh(refresh_r),
      .req(tx_prio0_pause_request),
      .frame_valid_r(tx_pfc_frame_valid),
      .frame_r(tx_pfc_frame),
      .xoff_evt_r(xoff_evt),
      .xon_evt_r(xon_evt)
   );

   pfcc_rx_pause u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(tick_r),
      .rx_en(ctrl_r[CTRL_RX_EN]),
      .frame_end(rx_frame_end),
      .info(rx_frame_info),
      .paused(paused)
   );

   // outputs
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign rx_prio0_paused = paused[0];
   assign rx_client_frame_done = done_r;
   assign rx_client_frame_good = good_r;
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking top_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ctrl_forward_a: assert property ( // [R01]
      ce && rx_frame_end && rx_frame_info.err_free &&
      rx_frame_info.is_ctrl && !ctrl_r[CTRL_RX_EN] |=>
      rx_client_frame_done && rx_client_frame_good)
      else $error("control frame not forwarded as good");
   sticky_set_a: assert property (
      ce && xoff_evt |=> int_sts_r[INT_XOFF] &&
      (irq || !$past(int_mask_r[INT_XOFF])))
      else $error("xoff event lost from status");
   bresp_hold_a: assert property (
      bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
      else $error("write response dropped before taken");
   write_c: cover property (bvalid_r && s_axi_bready && bresp_r == RESP_OKAY);
   irq_c: cover property (!irq ##1 irq);
endmodule // pfcc_top

// file: dv/pfcc_client_model.sv
// Purpose: client model, priority 0 pause request from receive fifo fill
// Assumes: fill counts words of a 64 word receive fifo
// Notes:   upper threshold 56 words, lower threshold 48 words
`timescale 1ns/1ps
module pfcc_client_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // fifo state
   input wire logic [6:0] fill,
   // request to the mac
   output logic req_r
);
   // hysteresis keeps the request steady between the two thresholds
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_r <= 1'b0;
      end else if (fill > 7'h38) begin
         req_r <= 1'b1;
      end else if (fill < 7'h30) begin
         req_r <= 1'b0;
      end
   end
endmodule // pfcc_client_model

// file: dv/tb_priority_flow_control_client.sv
// Purpose: register, pause request and pause receive checks
// Assumes: refresh shortened to 4 quanta to keep the run short
// Notes:   clock enable held high throughout
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb_priority_flow_control_client import pfcc_pkg::*; ;
   logic aclk, aresetn, awv, wv, bry, arv, rry, fend, got;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0] resp;
   logic [6:0] fill;
   wire awr, wrd, bv, arr, rv, frv, paused, done, good, irq, req;
   wire [1:0] br, rr;
   wire [31:0] rd;
   pfcc_frame_type frm;
   pfcc_rx_info_type info;
   int failures = 0, n_tests = 0, cyc = 0;
   pfcc_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry),
      .tx_prio0_pause_request(req), .tx_pfc_frame_valid(frv),
      .tx_pfc_frame(frm), .rx_frame_end(fend), .rx_frame_info(info),
      .rx_prio0_paused(paused), .rx_client_frame_done(done),
      .rx_client_frame_good(good), .irq(irq));
   pfcc_client_model client (.aclk(aclk), .aresetn(aresetn), .fill(fill),
      .req_r(req));
   // ----------------------------------------------------------------
   // clock, timeout and bus tasks
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // a hang anywhere ends the run as a failure
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         finish_test;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (bv !== 1'b1);
      resp = br;
      bry <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rdat = rd;
      resp = rr;
      rry <= 1'b0;
   endtask
   // waits up to lim cycles for a pause frame request
   task automatic wf(input int lim);
      got = 1'b0;
      for (int k = 0; k < lim && !got; k++) begin
         @(posedge aclk);
         got = (frv === 1'b1);
      end
   endtask
   // one matching priority 0 pause frame with quanta q
   task automatic rxf(input logic [15:0] q);
      @(posedge aclk);
      info <= {3'h7, P0_ENABLE, 112'h0, q};
      fend <= 1'b1;
      @(posedge aclk);
      fend <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic finish_test;
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      {awv, wv, bry, arv, rry, fend} = 6'h0;
      {awa, ara, wd, fill, info} = '0;
      aresetn = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(ADDR_CTRL);
      `CHK(rdat, 32'h00000007)
      rdr(ADDR_QUANTA);
      `CHK(rdat, 32'h0000FFFF)
      rdr(ADDR_REFRESH);
      `CHK(rdat, 32'h0000FF00)
      rdr(8'h3C);
      `CHK(resp, RESP_SLVERR)
      wr(ADDR_STATUS, 32'h00000001);
      `CHK(resp, RESP_SLVERR)
      wr(ADDR_REFRESH, 32'h00000004);
      `CHK(resp, RESP_OKAY)
      wr(ADDR_INT_MASK, 32'h00000002);
      // xoff, then a refresh while fill sits between thresholds
      fill <= 7'h3A;
      wf(20);
      `CHK(got, 1'b1)
      `CHK(frm.prio_en, P0_ENABLE)
      `CHK(frm.quanta[0], QUANTA_RST)
      fill <= 7'h34;
      wf(200);
      `CHK(got, 1'b1)
      `CHK(frm.quanta[0], QUANTA_RST)
      fill <= 7'h10;
      wf(20);
      `CHK(got, 1'b1)
      `CHK(frm.quanta[0], XON_QUANTA)
      rdr(ADDR_INT_STS);
      `CHK(rdat[INT_XON], 1'b1)
      `CHK(irq, 1'b1)
      wr(ADDR_INT_STS, 32'h00000002);
      `CHK(irq, 1'b0)
      // release with auto xon off sends nothing
      wr(ADDR_CTRL, 32'h00000003);
      fill <= 7'h3A;
      wf(20);
      `CHK(got, 1'b1)
      fill <= 7'h10;
      wf(60);
      `CHK(got, 1'b0)
      // receive: count down, then zero quanta cut short
      rxf(16'h0003);
      `CHK({paused, done, good}, 3'h6)
      repeat (3) @(posedge aclk);
      `CHK(paused, 1'b1)
      repeat (9) @(posedge aclk);
      `CHK(paused, 1'b0)
      rxf(16'hFFFF);
      `CHK(paused, 1'b1)
      rxf(XON_QUANTA);
      `CHK(paused, 1'b0)
      // receive off: control frame goes to the client as good
      wr(ADDR_CTRL, 32'h00000005);
      rxf(16'h0003); // client must drop this frame itself
      `CHK({paused, done, good}, 3'h3)
      // transmit off: a rising request sends no frame
      wr(ADDR_CTRL, 32'h00000004);
      fill <= 7'h3A;
      wf(20);
      `CHK(got, 1'b0)
      finish_test;
   end
endmodule // tb_priority_flow_control_client
